// >>> src/nvmac_consts.vh
/*
 * constants of the nvm access controller: register offsets, control
 * field positions, mode codes, stall and arm counts, programming ticks.
 * assumes inclusion by the controller files only, by bare name.
 */
`ifndef NVMAC_CONSTS_VH
`define NVMAC_CONSTS_VH

// i/o offsets of the four registers
`define NVMAC_OFS_ADDR_LOW 8'h21
`define NVMAC_OFS_ADDR_HIGH 8'h22
`define NVMAC_OFS_DATA 8'h23
`define NVMAC_OFS_CONTROL 8'h24

// control register field positions
`define NVMAC_BIT_READ_STROBE 0
`define NVMAC_BIT_WRITE_STROBE 1
`define NVMAC_BIT_ARM 2
`define NVMAC_BIT_READY_IRQ_EN 3
`define NVMAC_BIT_MODE_LO 4
`define NVMAC_BIT_MODE_HI 5

// programming mode codes
`define NVMAC_MODE_ATOMIC 2'h0
`define NVMAC_MODE_ERASE 2'h1
`define NVMAC_MODE_WRITE 2'h2
`define NVMAC_MODE_RESERVED 2'h3
`define NVMAC_MODE_RESET 2'h0

// reset values
`define NVMAC_DATA_RESET 8'h00
`define NVMAC_ZERO_BYTE 8'h00

// cpu clock cycle counts
`define NVMAC_ARM_CYCLES 3'h4
`define NVMAC_WRITE_STALL 3'h2
`define NVMAC_READ_STALL 3'h4

// typical programming times in microseconds
`define NVMAC_TIME_ATOMIC_US 3400
`define NVMAC_TIME_SPLIT_US 1800
`define NVMAC_TIME_CPU_WRITE_US 3300

// calibrated oscillator ticks per programming operation
`define NVMAC_TICKS_ATOMIC 26368
`define NVMAC_TICKS_SPLIT 13184
`define NVMAC_TICK_W 15

`endif

// >>> src/nvmac_sync.v
/*
 * two flip-flop synchroniser for one asynchronous level, with a rising
 * edge pulse taken from the synchronised side only.
 * assumes the input toggles slower than half the cpu clock.
 */
`timescale 1ns/100ps
module nvmac_sync
(
    input wire i_ref_clk,
    input wire i_reset,
    input wire i_async,
    output wire o_level,
    output wire o_rise
);
    reg meta;
    reg stable;
    reg stable_d;

    // meta feeds stable and nothing else
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
        end
        else
        begin
            meta <= i_async;
            stable <= meta;
            stable_d <= stable;
        end
    end

    assign o_level = stable;
    assign o_rise = stable & ~stable_d;
endmodule

// >>> src/nvmac_down_counter.v
/*
 * loadable down counter that stops at zero.
 * assumes clear, load and step come from the same clock domain;
 * clear wins over load, load wins over step.
 */
`timescale 1ns/100ps
module nvmac_down_counter
#(
    parameter W = 4
)
(
    input wire i_ref_clk,
    input wire i_clear,
    input wire i_load,
    input wire [W-1:0] i_value,
    input wire i_step,
    output reg [W-1:0] o_count,
    output wire o_nonzero
);
    assign o_nonzero = |o_count;

    always @(posedge i_ref_clk)
    begin
        if (i_clear)
            o_count <= {W{1'b0}};
        else if (i_load)
            o_count <= i_value;
        else if (i_step && o_nonzero)
            o_count <= o_count - {{(W-1){1'b0}}, 1'b1};
    end
endmodule

// >>> src/nvmac_top.v
/*
 * nvm access controller: address, data and control registers on the
 * cpu i/o port, arm time-out, cpu stall, self-timed programming.
 * assumes a combinational array read on o_mem_addr while o_mem_rd is
 * high, an asynchronous calibrated oscillator on i_osc_clk, and cpu
 * side signals (global irq enable, flash busy) on the cpu clock.
 */
`timescale 1ns/100ps
`include "nvmac_consts.vh"

// Notes on behaviour
// - nine-bit linear byte address
// - address register keeps content through reset
// - address bits 15..9 read zero
// - control bits 7..6 read zero
// - data register feeds writes, holds read byte
// - mode field selects atomic, erase, write
// - mode writes ignored while strobe set
// - system reset clears mode unless programming
// - ready irq level while strobe reads zero
// - no ready irq during programming or flash
// - arm bit self-clears four cycles later
// - strobe starts programming only while armed
// - strobe stays set until interval ends
// - write strobe stalls cpu two cycles
// - read fetches byte, stalls cpu four
// - programming blocks reads and address changes
// - interval counted on calibrated oscillator ticks
// - programming survives system reset to completion
module nvmac_top
#(
    parameter P_ADDR_W = 9,
    parameter P_TICKS_ATOMIC = `NVMAC_TICKS_ATOMIC,
    parameter P_TICKS_SPLIT = `NVMAC_TICKS_SPLIT
)
(
    input wire i_ref_clk,
    input wire i_reset,
    input wire i_power_on,
    input wire [7:0] i_io_addr,
    input wire i_io_wr,
    input wire i_io_rd,
    input wire [7:0] i_io_wdata,
    output reg [7:0] o_io_rdata,
    input wire i_global_irq_en,
    input wire i_flash_selfprog_busy,
    input wire i_osc_clk,
    input wire [7:0] i_mem_rdata,
    output reg [P_ADDR_W-1:0] o_mem_addr,
    output reg [7:0] o_mem_wdata,
    output reg [1:0] o_mem_mode,
    output reg o_mem_prog,
    output reg o_mem_rd,
    output reg o_cpu_stall,
    output reg o_ready_irq
);
    localparam [`NVMAC_TICK_W-1:0] TICKS_ATOMIC =
        P_TICKS_ATOMIC[`NVMAC_TICK_W-1:0];
    localparam [`NVMAC_TICK_W-1:0] TICKS_SPLIT =
        P_TICKS_SPLIT[`NVMAC_TICK_W-1:0];

    // register state
    reg [P_ADDR_W-1:0] nvm_address_field;
    reg [7:0] nvm_data;
    reg [1:0] program_mode;
    reg ready_irq_enable;
    reg busy;

    // access decode
    wire hit_addr_low;
    wire hit_addr_high;
    wire hit_data;
    wire hit_control;
    wire wr_addr_low;
    wire wr_addr_high;
    wire wr_data;
    wire wr_control;

    // control events
    wire master_write_arm;
    wire start_prog;
    wire read_go;
    wire arm_load;
    wire prog_left;
    wire osc_tick;
    wire stall_left;
    wire next_busy;
    wire prog_clear;
    wire io_live;

    reg [`NVMAC_TICK_W-1:0] next_ticks;
    reg [7:0] next_rdata;
    reg [2:0] next_stall;

    wire [15:0] addr_ext;
    wire [7:0] control_view;
    wire [2:0] arm_count;
    wire [2:0] stall_count;
    wire [`NVMAC_TICK_W-1:0] prog_count;

    assign hit_addr_low = (i_io_addr == `NVMAC_OFS_ADDR_LOW);
    assign hit_addr_high = (i_io_addr == `NVMAC_OFS_ADDR_HIGH);
    assign hit_data = (i_io_addr == `NVMAC_OFS_DATA);
    assign hit_control = (i_io_addr == `NVMAC_OFS_CONTROL);

    assign wr_addr_low = i_io_wr & hit_addr_low;
    assign wr_addr_high = i_io_wr & hit_addr_high;
    assign wr_data = i_io_wr & hit_data;
    assign wr_control = i_io_wr & hit_control;

    // nothing written during either reset may start an access
    assign io_live = ~i_reset & ~i_power_on;

    // rising edges only; a stopped oscillator stalls the interval
    // oscillator is asynchronous, so only its synchronised edge counts
    nvmac_sync u_osc_sync
    (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_power_on),
        .i_async(i_osc_clk),
        .o_level(),
        .o_rise(osc_tick)
    );

    // re-arming while armed does not stretch the window
    assign arm_load = wr_control & i_io_wdata[`NVMAC_BIT_ARM]
        & ~master_write_arm & io_live;

    nvmac_down_counter #(.W(3)) u_arm
    (
        .i_ref_clk(i_ref_clk),
        .i_clear(i_reset | i_power_on),
        .i_load(arm_load),
        .i_value(`NVMAC_ARM_CYCLES),
        .i_step(1'b1),
        .o_count(arm_count),
        .o_nonzero(master_write_arm)
    );

    // strobe honoured only inside the arm window, never for code 11,
    // never while the flash store op runs
    assign start_prog = wr_control & i_io_wdata[`NVMAC_BIT_WRITE_STROBE]
        & master_write_arm & ~busy & ~i_flash_selfprog_busy
        & (program_mode != `NVMAC_MODE_RESERVED)
        & io_live;

    // a write strobe that starts programming in the same write takes precedence over a read
    assign read_go = wr_control & i_io_wdata[`NVMAC_BIT_READ_STROBE]
        & ~busy & ~start_prog & io_live;

    // reserved code loads nothing; the start is refused anyway
    always @*
    begin
        case (program_mode)
            `NVMAC_MODE_ATOMIC: next_ticks = TICKS_ATOMIC;
            `NVMAC_MODE_ERASE: next_ticks = TICKS_SPLIT;
            `NVMAC_MODE_WRITE: next_ticks = TICKS_SPLIT;
            default: next_ticks = {`NVMAC_TICK_W{1'b0}};
        endcase
    end

    // only power-on clears a running interval; system reset spares it
    assign prog_clear = i_power_on | (i_reset & ~busy);

    // interval ends on the tick that empties the counter;
    // the synchroniser adds two cycles of lag to every tick
    nvmac_down_counter #(.W(`NVMAC_TICK_W)) u_prog
    (
        .i_ref_clk(i_ref_clk),
        .i_clear(prog_clear),
        .i_load(start_prog),
        .i_value(next_ticks),
        .i_step(busy & osc_tick),
        .o_count(prog_count),
        .o_nonzero(prog_left)
    );

    assign next_busy = start_prog | (busy & prog_left);

    // write and read exclude each other, so one counter serves both
    always @*
    begin
        if (start_prog)
            next_stall = `NVMAC_WRITE_STALL;
        else
            next_stall = `NVMAC_READ_STALL;
    end

    nvmac_down_counter #(.W(3)) u_stall
    (
        .i_ref_clk(i_ref_clk),
        .i_clear(i_reset | i_power_on),
        .i_load(start_prog | read_go),
        .i_value(next_stall),
        .i_step(1'b1),
        .o_count(stall_count),
        .o_nonzero(stall_left)
    );

    // busy flag, survives system reset while an interval runs
    // a start never meets an end: a start needs busy low
    always @(posedge i_ref_clk)
    begin
        if (i_power_on)
            busy <= 1'b0;
        else
            busy <= next_busy;
    end

    // address register: never reset, frozen while programming
    // only bit 0 of the high byte is kept, as address bit 8; the rest read zero
    always @(posedge i_ref_clk)
    begin
        if (!busy)
        begin
            if (wr_addr_low)
                nvm_address_field[7:0] <= i_io_wdata;
            if (wr_addr_high)
                nvm_address_field[P_ADDR_W-1:8] <=
                    i_io_wdata[P_ADDR_W-9:0];
        end
    end

    // data register: cpu write or byte fetched by a read
    // fetch outranks a same-cycle data write
    always @(posedge i_ref_clk)
    begin
        if (i_reset || i_power_on)
            nvm_data <= `NVMAC_DATA_RESET;
        else if (o_mem_rd)
            nvm_data <= i_mem_rdata;
        else if (wr_data)
            nvm_data <= i_io_wdata;
    end

    // mode and irq enable
    // irq enable is not locked: software may change it mid-interval
    always @(posedge i_ref_clk)
    begin
        if (i_power_on)
        begin
            program_mode <= `NVMAC_MODE_RESET;
            ready_irq_enable <= 1'b0;
        end
        else if (i_reset)
        begin
            if (!busy)
                program_mode <= `NVMAC_MODE_RESET;
            ready_irq_enable <= 1'b0;
        end
        else if (wr_control)
        begin
            if (!busy)
                program_mode <= i_io_wdata[`NVMAC_BIT_MODE_HI:
                    `NVMAC_BIT_MODE_LO];
            ready_irq_enable <= i_io_wdata[`NVMAC_BIT_READY_IRQ_EN];
        end
    end

    // values presented to the array, held for the whole interval
    // a read moves only the address; the byte to program stays put
    always @(posedge i_ref_clk)
    begin
        if (i_power_on || (i_reset && !busy))
        begin
            o_mem_addr <= {P_ADDR_W{1'b0}};
            o_mem_wdata <= `NVMAC_ZERO_BYTE;
            o_mem_mode <= `NVMAC_MODE_RESET;
        end
        else if (start_prog)
        begin
            o_mem_addr <= nvm_address_field;
            o_mem_wdata <= nvm_data;
            o_mem_mode <= program_mode;
        end
        else if (read_go)
            o_mem_addr <= nvm_address_field;
    end

    // array strobes and cpu halt
    always @(posedge i_ref_clk)
    begin
        if (i_power_on)
        begin
            o_mem_prog <= 1'b0;
            o_mem_rd <= 1'b0;
            o_cpu_stall <= 1'b0;
        end
        else if (i_reset)
        begin
            o_mem_prog <= next_busy;
            o_mem_rd <= 1'b0;
            o_cpu_stall <= 1'b0;
        end
        else
        begin
            o_mem_prog <= next_busy;
            o_mem_rd <= read_go;
            // the load edge is a stall cycle itself, hence count above 1
            o_cpu_stall <= start_prog | read_go
                | (stall_count > 3'h1);
        end
    end

    // level request; flash store op suppresses it as well
    always @(posedge i_ref_clk)
    begin
        if (i_reset || i_power_on)
            o_ready_irq <= 1'b0;
        else
            o_ready_irq <= ready_irq_enable & i_global_irq_en
                & ~next_busy & ~i_flash_selfprog_busy;
    end

    // read-back views; unused bits fixed at zero
    assign addr_ext = {{(16-P_ADDR_W){1'b0}}, nvm_address_field};
    assign control_view = {2'b00, program_mode, ready_irq_enable,
        master_write_arm, busy, 1'b0};

    // unmapped offsets read zero
    always @*
    begin
        case (1'b1)
            hit_addr_low: next_rdata = addr_ext[7:0];
            hit_addr_high: next_rdata = addr_ext[15:8];
            hit_data: next_rdata = nvm_data;
            hit_control: next_rdata = control_view;
            default: next_rdata = `NVMAC_ZERO_BYTE;
        endcase
    end

    always @(posedge i_ref_clk)
    begin
        if (i_reset || i_power_on)
            o_io_rdata <= `NVMAC_ZERO_BYTE;
        else if (i_io_rd)
            o_io_rdata <= next_rdata;
    end
endmodule

// >>> verification/nvmac_checker.sv
/*
 * port-level assertions for the nvm access controller.
 * assumes binding to nvmac_top, one cpu clock domain.
 */
`timescale 1ns/100ps
`include "nvmac_consts.vh"
module nvmac_checker
#(
    parameter P_ADDR_W = 9
)
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_power_on,
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_global_irq_en,
    input wire logic i_flash_selfprog_busy,
    input wire logic [P_ADDR_W-1:0] o_mem_addr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [1:0] o_mem_mode,
    input wire logic o_mem_prog,
    input wire logic o_mem_rd,
    input wire logic o_cpu_stall,
    input wire logic o_ready_irq
);
    wire ctl_wr;
    wire arm_wr;
    wire str_wr;
    wire rd_req;
    assign ctl_wr = i_io_wr && i_io_addr == `NVMAC_OFS_CONTROL;
    assign arm_wr = ctl_wr && i_io_wdata[2] && !i_io_wdata[1];
    assign str_wr = ctl_wr && i_io_wdata[1];
    assign rd_req = ctl_wr && i_io_wdata[0] && !i_io_wdata[1] && !o_mem_prog;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset || i_power_on);
    sequence s_read_stall;
        o_cpu_stall [*4] ##1 !o_cpu_stall;
    endsequence
    sequence s_write_stall;
        o_cpu_stall [*2] ##1 !o_cpu_stall;
    endsequence
    AST_READ_FETCH: assert property (rd_req |=> o_mem_rd)
        else $error("read strobe gave no array read");
    AST_READ_STALL: assert property ($rose(o_mem_rd)
        |-> s_read_stall)
        else $error("read stall is not four cycles");
    AST_WRITE_STALL: assert property ($rose(o_mem_prog)
        |-> s_write_stall)
        else $error("write stall is not two cycles");
    AST_START_ARMED: assert property ($rose(o_mem_prog)
        |-> $past(str_wr)
        && ($past(arm_wr, 2) || $past(arm_wr, 3) || $past(arm_wr, 4)
        || $past(arm_wr, 5)))
        else $error("programming began without armed strobe");
    AST_HOLD: assert property (o_mem_prog && $past(o_mem_prog)
        |-> $stable(o_mem_addr) && $stable(o_mem_wdata)
        && $stable(o_mem_mode))
        else $error("captured values moved during programming");
    AST_NO_READ_BUSY: assert property (o_mem_prog |-> !o_mem_rd)
        else $error("array read during programming");
    AST_MODE_LEGAL: assert property (o_mem_prog
        |-> o_mem_mode != 2'h3)
        else $error("reserved mode programmed");
    // request is registered: busy shows at once, flash one cycle late
    AST_IRQ_QUIET: assert property ((o_mem_prog
        || $past(i_flash_selfprog_busy)) |-> !o_ready_irq)
        else $error("ready irq while busy");
    AST_IRQ_GLOBAL: assert property (!i_global_irq_en
        |=> !o_ready_irq)
        else $error("ready irq with global enable off");
endmodule
bind nvmac_top nvmac_checker #(.P_ADDR_W(P_ADDR_W)) i_checker (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_power_on(i_power_on),
    .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata),
    .i_global_irq_en(i_global_irq_en),
    .i_flash_selfprog_busy(i_flash_selfprog_busy),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_mem_mode(o_mem_mode), .o_mem_prog(o_mem_prog), .o_mem_rd(o_mem_rd),
    .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq));

// >>> verification/testbench.sv
/*
 * self-checking bench for the nvm access controller.
 * assumes short tick parameters and a free oscillator.
 */
`timescale 1ns/100ps
module testbench;
    localparam TA = 20;
    localparam TS = 10;
    logic i_ref_clk = 0;
    logic i_osc_clk = 0;
    logic i_reset = 1;
    logic i_power_on = 1;
    logic i_io_wr = 0;
    logic i_io_rd = 0;
    logic i_global_irq_en = 0;
    logic i_flash_selfprog_busy = 0;
    logic [7:0] i_io_addr = 0;
    logic [7:0] i_io_wdata = 0;
    wire [7:0] o_io_rdata;
    wire [7:0] o_mem_wdata;
    wire [7:0] i_mem_rdata;
    wire [8:0] o_mem_addr;
    wire [1:0] o_mem_mode;
    wire o_mem_prog;
    wire o_mem_rd;
    wire o_cpu_stall;
    wire o_ready_irq;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int ticks = 0;
    initial forever #2 i_ref_clk = ~i_ref_clk;
    initial forever #7 i_osc_clk = ~i_osc_clk;
    // inverse outside a read so a stale byte cannot pass
    assign i_mem_rdata = o_mem_rd ? o_mem_addr[7:0] ^ 8'h3c
                                  : ~(o_mem_addr[7:0] ^ 8'h3c);
    nvmac_top #(.P_ADDR_W(9), .P_TICKS_ATOMIC(TA), .P_TICKS_SPLIT(TS)) i_dut (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_power_on(i_power_on),
        .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
        .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
        .i_global_irq_en(i_global_irq_en),
        .i_flash_selfprog_busy(i_flash_selfprog_busy),
        .i_osc_clk(i_osc_clk), .i_mem_rdata(i_mem_rdata),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .o_mem_mode(o_mem_mode), .o_mem_prog(o_mem_prog),
        .o_mem_rd(o_mem_rd), .o_cpu_stall(o_cpu_stall),
        .o_ready_irq(o_ready_irq));
    always @(posedge i_osc_clk)
        if (o_mem_prog === 1'b1) ticks <= ticks + 1;
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            test_done;
        end
    end
    task test_done;
        $display("counts: mismatches=%0d checks=%0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_io_addr = a;
        i_io_wdata = d;
        i_io_wr = 1;
        @(negedge i_ref_clk);
        i_io_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_ref_clk);
        i_io_addr = a;
        i_io_rd = 1;
        @(negedge i_ref_clk);
        i_io_rd = 0;
        chk(o_io_rdata, exp);
    endtask
    // counts stall cycles from the cycle after the strobe
    task stall_len(input int exp);
        int n;
        n = 0;
        while (o_cpu_stall === 1'b1 && n < 20)
        begin
            n++;
            @(negedge i_ref_clk);
        end
        chk(16'(n), 16'(exp));
    endtask
    task prog(input logic [1:0] m, input logic [7:0] d);
        wr(8'h23, d);
        wr(8'h24, {2'b0, m, 4'h0});
        wr(8'h24, {2'b0, m, 4'h4});
        ticks = 0;
        wr(8'h24, {2'b0, m, 4'h2});
    endtask
    task wait_done(input int exp);
        int n;
        n = 0;
        while (o_mem_prog === 1'b1 && n < 2000)
        begin
            n++;
            @(negedge i_ref_clk);
        end
        // synchroniser lag blurs the first tick by one
        chk(16'(ticks >= exp - 1 && ticks <= exp + 1), 16'h1);
    endtask
    initial
    begin
        repeat (2) @(negedge i_ref_clk);
        i_reset = 0;
        @(negedge i_ref_clk);
        i_power_on = 0;
        rd(8'h24, 8'h00);
        wr(8'h21, 8'ha5);
        wr(8'h22, 8'hff);
        rd(8'h22, 8'h01);
        rd(8'h21, 8'ha5);
        rd(8'h30, 8'h00);
        wr(8'h24, 8'h01);
        chk(o_mem_rd, 1);
        chk(o_mem_addr, 9'h1a5);
        stall_len(4);
        rd(8'h23, 8'h99);
        wr(8'h24, 8'h02);
        rd(8'h24, 8'h00);
        wr(8'h24, 8'h04);
        rd(8'h24, 8'h04);
        repeat (4) @(negedge i_ref_clk);
        rd(8'h24, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            wr(8'h21, 8'h10 + 8'(m));
            wr(8'h22, 8'h00);
            prog(2'(m), 8'hc0 + 8'(m));
            chk(o_mem_prog, 1);
            chk(o_mem_mode, 16'(m));
            chk(o_mem_addr, 9'h010 + 9'(m));
            chk(o_mem_wdata, 8'hc0 + 8'(m));
            stall_len(2);
            i_global_irq_en = 1;
            wr(8'h24, 8'h39);
            chk(o_mem_rd, 0);
            rd(8'h24, {2'b0, 2'(m), 4'ha});
            chk(o_ready_irq, 0);
            wr(8'h21, 8'hff);
            rd(8'h21, 8'h10 + 8'(m));
            wait_done(m == 0 ? TA : TS);
            chk(o_ready_irq, 1);
            i_global_irq_en = 0;
            rd(8'h24, {2'b0, 2'(m), 4'h8});
        end
        prog(2'h3, 8'h5a);
        chk(o_mem_prog, 0);
        i_flash_selfprog_busy = 1;
        prog(2'h2, 8'h5a);
        chk(o_mem_prog, 0);
        i_global_irq_en = 1;
        wr(8'h24, 8'h08);
        @(negedge i_ref_clk);
        chk(o_ready_irq, 0);
        i_flash_selfprog_busy = 0;
        @(negedge i_ref_clk);
        chk(o_ready_irq, 1);
        i_global_irq_en = 0;
        @(negedge i_ref_clk);
        chk(o_ready_irq, 0);
        prog(2'h2, 8'h77);
        stall_len(2);
        i_reset = 1;
        repeat (2) @(negedge i_ref_clk);
        i_reset = 0;
        chk(o_mem_prog, 1);
        rd(8'h24, 8'h22);
        wait_done(TS);
        i_reset = 1;
        @(negedge i_ref_clk);
        i_reset = 0;
        rd(8'h24, 8'h00);
        rd(8'h21, 8'h12);
        test_done;
    end
endmodule
